// ==== wkev_pkg.sv ====
package wkev_pkg;
    localparam logic [7:0] WKEV_ADDR_HARDWARE_CONFIG_REG = 8'h74;
    localparam logic [7:0] WKEV_ADDR_BYTE_TEST = 8'h64;
    localparam logic [7:0] WKEV_ADDR_PMCTRL = 8'h84;
    localparam logic [7:0] WKEV_ADDR_SOURCE = 8'h8C;
    localparam int WKEV_BIT_READY = 0;
    localparam int WKEV_BIT_OUT_EN = 1;
    localparam int WKEV_BIT_POL = 2;
    localparam int WKEV_BIT_PULSE = 3;
    localparam int WKEV_BIT_STS_LO = 4;
    localparam int WKEV_BIT_TYPE = 6;
    localparam int WKEV_BIT_ENERGY_WAKE_ENABLE = 8;
    localparam int WKEV_BIT_FW_EN = 9;
    localparam int WKEV_BIT_MODE_LO = 12;
    localparam logic [1:0] WKEV_MODE_FULL = 2'h0;
    localparam logic [1:0] WKEV_MODE_FRAME = 2'h1;
    localparam logic [1:0] WKEV_MODE_ENERGY = 2'h2;
    localparam int WKEV_CLK_HZ = 20000000;
    localparam int WKEV_PULSE_MS = 50;
    localparam int WKEV_PULSE_CYC = WKEV_CLK_HZ / 1000 * WKEV_PULSE_MS;
    localparam int WKEV_SETTLE_CYC = 16;
endpackage : wkev_pkg

// ==== wkev_ctrl.sv ====
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - wake_status shows cause: energy, frame, or both (11).
// - a status bit clears only on a written one.
// - clearing works only in full power with ready set.
// - pulse mode: output active for 50 ms when a wake event sets a clear status bit.
// - level mode: output held active until deactivated.
// - output drops when status cleared or its enable cleared.
// - push-pull polarity follows event_polarity.
// - open-drain ignores polarity, always active low.
// - pin driven only while event_output_enable set.
// - interrupt independent of event_output_enable.
// - ready set only after settling, on power-up or wake.
// - control register readable in any power state.
// - power_state_select: full, frame wake, energy wake; 11 reserved.
// - driver type clear means open drain, set push-pull.
// - enabled wake events raise interrupt and output.
// - any write to byte test register wakes the device.
module wkev_ctrl
    import wkev_pkg::*;
#(
    parameter int PULSE_CYC = WKEV_PULSE_CYC,
    parameter int SETTLE_CYC = WKEV_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic energy_event_pin,
    input wire logic frame_event_pin,
    output logic power_event_o,
    output logic power_event_oe,
    output logic power_event_interrupt,
    output logic [1:0] power_state
);
    logic [1:0] ed_sync;
    logic [1:0] fw_sync;
    logic [1:0] mode, next_mode;
    logic [1:0] status, next_status;
    logic pulse_sel, next_pulse_sel;
    logic pol, next_pol;
    logic out_en, next_out_en;
    logic drv_type, next_drv_type;
    logic energy_wake_enable, next_energy_wake_enable;
    logic fw_en, next_fw_en;
    logic ready, next_ready;
    logic [31:0] settle_cnt, next_settle_cnt;
    logic [31:0] pulse_cnt, next_pulse_cnt;
    logic active, next_active;
    logic [31:0] next_rdata;
    logic next_pe_o, next_pe_oe, next_int;
    logic ed_hit, fw_hit, wr_ctrl, clr_ok;

    // address decode, shared by the write, wake and read paths
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction : addr_hit

    always_ff @(posedge clk) begin
        if (rst) begin
            ed_sync <= 2'h0;
            fw_sync <= 2'h0;
        end else begin
            ed_sync <= {ed_sync[0], energy_event_pin};
            fw_sync <= {fw_sync[0], frame_event_pin};
        end
    end

    always_comb begin
        wr_ctrl = wr && addr_hit(addr, WKEV_ADDR_PMCTRL);
        // events count only while their enable is set, in every power state
        ed_hit = ed_sync[1] && energy_wake_enable;
        fw_hit = fw_sync[1] && fw_en;
        clr_ok = ready && (mode == WKEV_MODE_FULL);
        next_mode = mode;
        next_pulse_sel = pulse_sel;
        next_pol = pol;
        next_out_en = out_en;
        next_drv_type = drv_type;
        next_energy_wake_enable = energy_wake_enable;
        next_fw_en = fw_en;
        next_status = status;
        next_ready = ready;
        next_settle_cnt = settle_cnt;
        if (wr_ctrl) begin
            next_pulse_sel = wdata[WKEV_BIT_PULSE];
            next_pol = wdata[WKEV_BIT_POL];
            next_out_en = wdata[WKEV_BIT_OUT_EN];
            next_drv_type = wdata[WKEV_BIT_TYPE];
            next_energy_wake_enable = wdata[WKEV_BIT_ENERGY_WAKE_ENABLE];
            next_fw_en = wdata[WKEV_BIT_FW_EN];
            // reserved encoding is refused, state kept
            if (wdata[WKEV_BIT_MODE_LO+:2] != 2'h3) begin
                next_mode = wdata[WKEV_BIT_MODE_LO+:2];
            end
            // leaving full power restarts the settle count for the next wake
            if (next_mode != WKEV_MODE_FULL) begin
                next_ready = 1'b0;
                next_settle_cnt = 32'h0;
            end
            if (clr_ok) begin
                next_status = status & ~wdata[WKEV_BIT_STS_LO+:2];
            end
        end
        // wake by write to byte test, or by an enabled event
        if (mode != WKEV_MODE_FULL) begin
            if ((wr && addr_hit(addr, WKEV_ADDR_BYTE_TEST)) || ed_hit || fw_hit) begin
                next_mode = WKEV_MODE_FULL;
                next_ready = 1'b0;
                next_settle_cnt = 32'h0;
            end
        end
        // ready only after a settle period in full power
        // a sleep write in the settling cycle must not let ready slip through
        if (mode == WKEV_MODE_FULL && next_mode == WKEV_MODE_FULL && !ready) begin
            if (settle_cnt >= 32'(SETTLE_CYC - 1)) begin
                next_ready = 1'b1;
            end else begin
                next_settle_cnt = settle_cnt + 32'h1;
            end
        end
        // set wins over clear
        if (ed_hit) begin
            next_status[0] = 1'b1;
        end
        if (fw_hit) begin
            next_status[1] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= WKEV_MODE_FULL;
            pulse_sel <= 1'b0;
            pol <= 1'b0;
            out_en <= 1'b0;
            drv_type <= 1'b0;
            energy_wake_enable <= 1'b0;
            fw_en <= 1'b0;
            status <= 2'h0;
            ready <= 1'b0;
            settle_cnt <= 32'h0;
        end else begin
            mode <= next_mode;
            pulse_sel <= next_pulse_sel;
            pol <= next_pol;
            out_en <= next_out_en;
            drv_type <= next_drv_type;
            energy_wake_enable <= next_energy_wake_enable;
            fw_en <= next_fw_en;
            status <= next_status;
            ready <= next_ready;
            settle_cnt <= next_settle_cnt;
        end
    end

    // event output and its pulse timer
    always_comb begin
        next_active = active;
        next_pulse_cnt = pulse_cnt;
        if ((ed_hit && !status[0]) || (fw_hit && !status[1])) begin
            next_active = 1'b1;
            next_pulse_cnt = 32'h0;
        end else if (active && pulse_sel) begin
            if (pulse_cnt >= 32'(PULSE_CYC - 1)) begin
                next_active = 1'b0;
            end else begin
                next_pulse_cnt = pulse_cnt + 32'h1;
            end
        end
        // in level mode the output only leaves on clear or disable
        if ((next_status & {fw_en, energy_wake_enable}) == 2'h0) begin
            next_active = 1'b0;
        end
        next_int = (next_status & {fw_en, energy_wake_enable}) != 2'h0;
        next_pe_oe = 1'b0;
        next_pe_o = 1'b0;
        if (out_en) begin
            if (drv_type) begin
                next_pe_oe = 1'b1;
                next_pe_o = next_active ? pol : ~pol;
            end else begin
                // open drain: pull low only while active
                next_pe_oe = next_active;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            active <= 1'b0;
            pulse_cnt <= 32'h0;
            power_event_o <= 1'b0;
            power_event_oe <= 1'b0;
            power_event_interrupt <= 1'b0;
            power_state <= WKEV_MODE_FULL;
        end else begin
            active <= next_active;
            pulse_cnt <= next_pulse_cnt;
            power_event_o <= next_pe_o;
            power_event_oe <= next_pe_oe;
            power_event_interrupt <= next_int;
            power_state <= next_mode;
        end
    end

    // register read, always answered for the control register
    always_comb begin
        next_rdata = 32'h0;
        if (rd && addr_hit(addr, WKEV_ADDR_PMCTRL)) begin
            next_rdata[WKEV_BIT_READY] = ready;
            next_rdata[WKEV_BIT_OUT_EN] = out_en;
            next_rdata[WKEV_BIT_POL] = pol;
            next_rdata[WKEV_BIT_PULSE] = pulse_sel;
            next_rdata[WKEV_BIT_STS_LO+:2] = status;
            next_rdata[WKEV_BIT_TYPE] = drv_type;
            next_rdata[WKEV_BIT_ENERGY_WAKE_ENABLE] = energy_wake_enable;
            next_rdata[WKEV_BIT_FW_EN] = fw_en;
            next_rdata[WKEV_BIT_MODE_LO+:2] = mode;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    a_status_clear_gate: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && !clr_ok && !rst) |=> ((status & $past(status)) == $past(status)))
        else $error("status cleared while not ready");
    a_status_set: assert property (@(posedge clk) disable iff (rst)
        ed_hit |=> status[0])
        else $error("energy event not recorded");
    a_od_low: assert property (@(posedge clk) disable iff (rst)
        (power_event_oe && !$past(drv_type)) |-> !power_event_o)
        else $error("open drain drove high");
    a_out_gated: assert property (@(posedge clk) disable iff (rst)
        !$past(out_en) |-> !power_event_oe)
        else $error("output driven while disabled");
    a_read_ready: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == WKEV_ADDR_PMCTRL) |=> rdata[WKEV_BIT_READY] == $past(ready))
        else $error("ready not readable");
    a_irq_no_en: assert property (@(posedge clk) disable iff (rst)
        (status[0] && energy_wake_enable && !(wr_ctrl && clr_ok && wdata[WKEV_BIT_STS_LO]))
        |=> power_event_interrupt)
        else $error("interrupt missing");
    a_mode_legal: assert property (@(posedge clk) disable iff (rst)
        mode != 2'h3)
        else $error("reserved mode entered");
    a_ready_full: assert property (@(posedge clk) disable iff (rst)
        ready |-> mode == WKEV_MODE_FULL)
        else $error("ready outside full power");
    a_wake_write: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == WKEV_ADDR_BYTE_TEST && !wr_ctrl) |=> mode == WKEV_MODE_FULL)
        else $error("byte test write did not wake");
    a_frame_set: assert property (@(posedge clk) disable iff (rst)
        fw_hit |=> status[1])
        else $error("frame event not recorded");
    a_no_stray_clear: assert property (@(posedge clk) disable iff (rst)
        !(wr_ctrl && clr_ok) |=> ((status & $past(status)) == $past(status)))
        else $error("status cleared without a clearing write");
    a_pulse_end: assert property (@(posedge clk) disable iff (rst)
        (active && pulse_sel && pulse_cnt == 32'(PULSE_CYC - 1) && !ed_hit && !fw_hit)
        |=> !active)
        else $error("pulse outlasted its period");
    a_pulse_bound: assert property (@(posedge clk) disable iff (rst)
        pulse_cnt < 32'(PULSE_CYC))
        else $error("pulse counter overran");
    a_level_hold: assert property (@(posedge clk) disable iff (rst)
        (active && !pulse_sel && (status & {fw_en, energy_wake_enable}) != 2'h0 && !wr_ctrl) |=> active)
        else $error("level output dropped early");
    a_clear_drops: assert property (@(posedge clk) disable iff (rst)
        ((status & {fw_en, energy_wake_enable}) == 2'h0 && !ed_hit && !fw_hit) |=> !active)
        else $error("output active with no enabled status");
    a_irq_idle: assert property (@(posedge clk) disable iff (rst)
        ((status & {fw_en, energy_wake_enable}) == 2'h0 && !ed_hit && !fw_hit) |=> !power_event_interrupt)
        else $error("interrupt with no enabled status");
    a_push_pol: assert property (@(posedge clk) disable iff (rst)
        (power_event_oe && $past(drv_type))
        |-> (power_event_o == (active ? $past(pol) : !$past(pol))))
        else $error("push-pull level wrong for polarity");
    a_od_active: assert property (@(posedge clk) disable iff (rst)
        ($past(out_en) && !$past(drv_type)) |-> (power_event_oe == active))
        else $error("open drain enable does not follow event");
    a_ready_settle: assert property (@(posedge clk) disable iff (rst)
        $rose(ready) |-> ($past(settle_cnt) == 32'(SETTLE_CYC - 1)))
        else $error("ready rose before settling");
    a_read_other: assert property (@(posedge clk) disable iff (rst)
        !(rd && addr == WKEV_ADDR_PMCTRL) |=> (rdata == 32'h0))
        else $error("read data outside a control read");
    a_state_out: assert property (@(posedge clk) disable iff (rst)
        power_state == mode)
        else $error("power state pin disagrees with mode");
    a_mode_refuse: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && wdata[WKEV_BIT_MODE_LO+:2] == 2'h3 && mode == WKEV_MODE_FULL)
        |=> (mode == WKEV_MODE_FULL))
        else $error("reserved mode write changed the state");
    a_wake_event: assert property (@(posedge clk) disable iff (rst)
        (mode != WKEV_MODE_FULL && (ed_hit || fw_hit)) |=> (mode == WKEV_MODE_FULL && !ready))
        else $error("enabled event did not wake");
    a_irq_frame: assert property (@(posedge clk) disable iff (rst)
        (status[1] && fw_en && !(wr_ctrl && clr_ok && wdata[WKEV_BIT_STS_LO + 1]))
        |=> power_event_interrupt)
        else $error("frame interrupt missing");
endmodule : wkev_ctrl

// ==== wkev_far_end.sv ====
`timescale 1ns/1ps
module wkev_far_end (
    input wire logic power_event_o,
    input wire logic power_event_oe,
    input wire logic [1:0] fire,
    output logic energy_event_pin,
    output logic frame_event_pin,
    output logic wake_line
);
    // board pull-up: a released pin reads high, so open drain idles high
    assign wake_line = power_event_oe ? power_event_o : 1'b1;
    // event sources are plain levels held by the host until it clears them
    assign energy_event_pin = fire[0];
    assign frame_event_pin = fire[1];
endmodule : wkev_far_end

// ==== test_wake_event_output_control.sv ====
`timescale 1ns/1ps
module test_wake_event_output_control;
    import wkev_pkg::*;
    localparam int PC = 20;
    localparam logic [7:0] CT = WKEV_ADDR_PMCTRL;
    logic clk, rst, wr, rd, oe, o, irq, e_pin, f_pin, wake_line;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] fire, pstate;
    int err_total, checks_done, cnt, n;
    wkev_ctrl #(.PULSE_CYC(PC), .SETTLE_CYC(16)) dut_u (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .energy_event_pin(e_pin),
        .frame_event_pin(f_pin), .power_event_o(o), .power_event_oe(oe),
        .power_event_interrupt(irq), .power_state(pstate));
    wkev_far_end far_u (.power_event_o(o), .power_event_oe(oe), .fire(fire),
        .energy_event_pin(e_pin), .frame_event_pin(f_pin), .wake_line(wake_line));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    // three edges: registered outputs behind the write have landed
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : wreg
    // bare read for polling; the caller compares once the wait is over
    task automatic rraw(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        rv = rdata;
        @(posedge clk);
    endtask : rraw
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        rraw(a);
        check(rv, exp);
    endtask : rreg
    task automatic ev(input logic [1:0] f, input int cyc);
        fire <= f;
        repeat (cyc) @(posedge clk);
    endtask : ev
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        fire = 2'b00;
        err_total = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rreg(CT, 32'h0);
        n = 0;
        // ready polling is bounded; a device that never settles ends the run
        do begin
            rraw(CT);
            n++;
        end while (rv[0] !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_total++;
            results();
        end
        check(rv, 32'h1);
        rreg(WKEV_ADDR_SOURCE, 32'h0);
        wreg(CT, 32'h142);
        check(32'(wake_line), 32'h1);
        wreg(CT, 32'h146);
        check(32'(wake_line), 32'h0);
        ev(2'b01, 40);
        rreg(CT, 32'h157);
        check(32'(irq), 32'h1);
        check(32'(wake_line), 32'h1);
        wreg(CT, 32'h156);
        rreg(CT, 32'h157);
        ev(2'b00, 4);
        wreg(CT, 32'h146);
        rreg(CT, 32'h157);
        wreg(CT, 32'h156);
        rreg(CT, 32'h147);
        check({30'h0, irq, wake_line}, 32'h0);
        wreg(CT, 32'h30E);
        check(32'(wake_line), 32'h1);
        fire <= 2'b10;
        cnt = 0;
        repeat (60) begin
            @(negedge clk);
            if (wake_line === 1'b0) cnt++;
        end
        @(posedge clk);
        check(cnt, PC);
        rreg(CT, 32'h32F);
        ev(2'b01, 8);
        ev(2'b00, 4);
        rreg(CT, 32'h33F);
        wreg(CT, 32'h33E);
        rreg(CT, 32'h30F);
        wreg(CT, 32'h100);
        ev(2'b01, 8);
        ev(2'b00, 4);
        check({30'h0, oe, irq}, 32'h1);
        wreg(CT, 32'h0);
        check(32'(irq), 32'h0);
        for (int m = 1; m <= 2; m++) begin
            wreg(CT, 32'(m) << 12);
            check(32'(pstate), 32'(m));
            rreg(CT, (32'(m) << 12) | 32'h10);
            wreg(WKEV_ADDR_BYTE_TEST, 32'h0);
            check(32'(pstate), 32'h0);
            // only the control register is touched until ready returns
            if (m == 1) wreg(CT, 32'h30);
            n = 0;
            do begin
                rraw(CT);
                n++;
            end while (rv[0] !== 1'b1 && n < 40);
            if (n >= 40) begin
                err_total++;
                results();
            end
            check(rv, 32'h11);
        end
        wreg(CT, 32'h30);
        rreg(CT, 32'h1);
        results();
    end
endmodule : test_wake_event_output_control
